// ---- relay_output_controller.sv ----
// Relay output controller: fail-safe, masking, inhibit, freeze, sleep,
// back-indication mismatch and failure reporting.
// Assumes CPU-side controls are synchronous to i_clk_sys; pins are not.
//
// Overview of operation
// - Eight or sixteen channels, chosen by variant parameter.
// - Energized relays drop on failure; latching relays hold last state.
// - Compare command with back indication; report disagreement to CPU.
// - Shorted inhibit input permits relays; open input inhibits all.
// - Inhibited: energized relays go 0; latching relays freeze.
// - Current inhibit status is readable by the user program.
// - Mismatch reporting suppressed while inhibited.
// - Two-bit switch picks inhibit enabled, software, or disabled (default).
// - Per-output fail-safe keep-last or predefined value on stop or link loss.
// - Mask forces predefined value in normal operation; default cleared.
// - Startup-reset option, default on, resets latching relays at startup.
// - User program may command sleep; module stops and idles.
// - On failure light error indicator and present failure status.
// - Freeze holds outputs at values present on entry.
// - Eight-channel: outputs 1-5 normally-open, 6-8 changeover.
`timescale 1ns/1ns
module relay_output_controller #(
    parameter int         N_CH          = relay_output_pkg::N_CH_16,
    parameter logic       LATCHING_TYPE = 1'b0
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rstn,
    input  wire logic [N_CH-1:0]    i_user_value,
    input  wire logic               i_program_running,
    input  wire logic               i_cpu_link_ok,
    input  wire logic [2*N_CH-1:0]  i_failsafe_cfg,
    input  wire logic [N_CH-1:0]    i_mask,
    input  wire logic [N_CH-1:0]    i_predefined_value,
    input  wire logic               i_startup_reset_en,
    input  wire logic               i_sw_inhibit_en,
    input  wire logic [1:0]         i_inhibit_mode_switch,
    input  wire logic               i_inhibit_control_input,
    input  wire logic               i_sleep_req,
    input  wire logic               i_freeze_req,
    input  wire logic               i_module_fault,
    input  wire logic [N_CH-1:0]    i_back_indication,
    input  wire logic               i_mismatch_read,
    output logic [N_CH-1:0]         o_relay_drive,
    output logic [N_CH-1:0]         o_latch_reset,
    output logic [N_CH-1:0]         o_form_c,
    output logic [N_CH-1:0]         o_mismatch,
    output logic                    o_inhibited,
    output logic                    o_failure,
    output logic                    o_err_led,
    output logic                    o_sleeping
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic ctl_closed;
    logic fb_sync [N_CH];
    logic [N_CH-1:0] fb;

    input_sync3 u_sync_ctl (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   (i_inhibit_control_input),
        .o_level   (ctl_closed)
    );

    for (genvar g = 0; g < N_CH; g++) begin : g_fb
        input_sync3 u_sync_fb (
            .i_clk_sys (i_clk_sys),
            .i_rstn    (i_rstn),
            .i_async   (i_back_indication[g]),
            .o_level   (fb_sync[g])
        );
        assign fb[g] = fb_sync[g];
    end

    // ****************************************
    // Variant wiring
    // ****************************************
    // Outputs 1-5 of each group of 8 are form A, 6-8 form C
    for (genvar g = 0; g < N_CH; g++) begin : g_form
        assign o_form_c[g] = ((g % relay_output_pkg::N_CH_8) >= relay_output_pkg::FORM_A_PER_8);
    end

    // ****************************************
    // Inhibit selection
    // ****************************************
    logic inhibit_enabled;
    logic inhibit_now;

    always_comb begin
        if (i_inhibit_mode_switch == relay_output_pkg::SW_BOTH_ON) begin
            inhibit_enabled = 1'b0;
        end else if (i_inhibit_mode_switch == relay_output_pkg::SW_FIRST_ON) begin
            inhibit_enabled = i_sw_inhibit_en;
        end else begin
            inhibit_enabled = 1'b1;
        end
    end

    assign inhibit_now = inhibit_enabled && !ctl_closed;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_inhibited <= 1'b0;
        end else begin
            o_inhibited <= inhibit_now;
        end
    end

    // ****************************************
    // Control state machine
    // ****************************************
    relay_output_pkg::ctrl_state_t state_r;
    relay_output_pkg::ctrl_state_t state_nxt;
    logic [2:0] start_cnt_r;
    logic       link_lost;

    assign link_lost = !i_program_running || !i_cpu_link_ok;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            relay_output_pkg::ST_STARTUP: begin
                if (start_cnt_r == 3'(relay_output_pkg::STARTUP_PULSE_CYC - 1)) begin
                    state_nxt = relay_output_pkg::ST_RUN;
                end
            end
            relay_output_pkg::ST_RUN: begin
                if (i_sleep_req) begin
                    state_nxt = relay_output_pkg::ST_SLEEP;
                end else if (link_lost) begin
                    state_nxt = relay_output_pkg::ST_FAILSAFE;
                end
            end
            relay_output_pkg::ST_FAILSAFE: begin
                if (i_sleep_req) begin
                    state_nxt = relay_output_pkg::ST_SLEEP;
                end else if (!link_lost) begin
                    state_nxt = relay_output_pkg::ST_RUN;
                end
            end
            relay_output_pkg::ST_SLEEP: begin
                if (!i_sleep_req) begin
                    state_nxt = relay_output_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = relay_output_pkg::ST_STARTUP;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= relay_output_pkg::ST_STARTUP;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            start_cnt_r <= 3'h0;
        end else if (state_r == relay_output_pkg::ST_STARTUP) begin
            start_cnt_r <= start_cnt_r + 3'h1;
        end
    end

    assign o_sleeping = (state_r == relay_output_pkg::ST_SLEEP);

    // ****************************************
    // Startup latch reset
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_latch_reset <= '0;
        end else begin
            o_latch_reset <= {N_CH{LATCHING_TYPE && i_startup_reset_en
                               && state_r == relay_output_pkg::ST_STARTUP}};
        end
    end

    // ****************************************
    // Output value selection
    // ****************************************
    logic            freeze_r;
    logic [N_CH-1:0] drive_nxt;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            freeze_r <= 1'b0;
        end else begin
            freeze_r <= i_freeze_req;
        end
    end

    always_comb begin
        drive_nxt = o_relay_drive;
        for (int i = 0; i < N_CH; i++) begin
            if (state_r == relay_output_pkg::ST_FAILSAFE) begin
                if (i_failsafe_cfg[2*i +: 2] == relay_output_pkg::FS_PREDEF_0) begin
                    drive_nxt[i] = 1'b0;
                end else if (i_failsafe_cfg[2*i +: 2] == relay_output_pkg::FS_PREDEF_1) begin
                    drive_nxt[i] = 1'b1;
                end
            end else if (state_r == relay_output_pkg::ST_RUN && !freeze_r && !i_freeze_req) begin
                drive_nxt[i] = i_mask[i] ? i_predefined_value[i] : i_user_value[i];
            end
        end
        if (i_module_fault) begin
            drive_nxt = LATCHING_TYPE ? o_relay_drive : '0;
        end else if (inhibit_now) begin
            drive_nxt = LATCHING_TYPE ? o_relay_drive : '0;
        end else if (state_r == relay_output_pkg::ST_STARTUP) begin
            drive_nxt = relay_output_pkg::RST_OUT[N_CH-1:0];
        end
    end

    // Freeze keeps the value held on entry
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_relay_drive <= relay_output_pkg::RST_OUT[N_CH-1:0];
        end else begin
            o_relay_drive <= drive_nxt;
        end
    end

    // ****************************************
    // Mismatch and failure
    // ****************************************
    logic [N_CH-1:0] mismatch_evt;

    assign mismatch_evt = (o_relay_drive ^ fb) & {N_CH{!o_inhibited && !o_sleeping}};

    // Set wins over the read-clear
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mismatch <= relay_output_pkg::RST_FLAGS[N_CH-1:0];
        end else if (i_mismatch_read) begin
            o_mismatch <= mismatch_evt;
        end else begin
            o_mismatch <= o_mismatch | mismatch_evt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_failure <= 1'b0;
        end else begin
            o_failure <= i_module_fault;
        end
    end

    assign o_err_led = o_failure;

    // ****************************************
    // Checks
    // ****************************************
    a_inhibit_ee_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (inhibit_now && !LATCHING_TYPE) |=> (o_relay_drive == '0))
        else $error("energized relays not dropped under inhibit");
    a_inhibit_ml_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (inhibit_now && LATCHING_TYPE) |=> $stable(o_relay_drive))
        else $error("latching relays changed under inhibit");
    a_fault_ee_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_module_fault && !LATCHING_TYPE) |=> (o_relay_drive == '0) && o_err_led)
        else $error("fault did not drop outputs");
    a_freeze_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (freeze_r && i_freeze_req && !i_module_fault && state_r == relay_output_pkg::ST_RUN
         && !inhibit_now) |=> $stable(o_relay_drive))
        else $error("frozen outputs changed");
    a_mask_force: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == relay_output_pkg::ST_RUN && !freeze_r && !i_freeze_req && !i_module_fault
         && !inhibit_now) |=> (o_relay_drive == (($past(i_mask) & $past(i_predefined_value))
         | (~$past(i_mask) & $past(i_user_value)))))
        else $error("masked output value wrong");
    a_inhibit_status: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_inhibit_mode_switch == relay_output_pkg::SW_BOTH_ON) [*2] |=> !o_inhibited)
        else $error("inhibit reported while disabled");
    a_mismatch_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_inhibited && i_mismatch_read) |=> (o_mismatch == '0))
        else $error("mismatch reported under inhibit");
    a_sleep_enter: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == relay_output_pkg::ST_RUN && i_sleep_req) |=> o_sleeping)
        else $error("sleep not entered");
    a_startup_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_rstn && state_r == relay_output_pkg::ST_STARTUP && LATCHING_TYPE && i_startup_reset_en)
        |=> (o_latch_reset == '1))
        else $error("latch reset pulse missing");
endmodule

// ---- relay_output_pkg.sv ----
// Package: constants and types shared by the relay output controller.
// Assumes a single 20 MHz system clock.
package relay_output_pkg;

    // ****************************************
    // Variant and layout
    // ****************************************
    localparam int N_CH_8         = 8;
    localparam int N_CH_16        = 16;
    localparam int N_CH_MAX       = 16;
    localparam int FORM_A_PER_8   = 5;

    // ****************************************
    // Inhibit mode switch encodings {sw2, sw1}
    // ****************************************
    localparam logic [1:0] SW_BOTH_OFF = 2'h0;
    localparam logic [1:0] SW_FIRST_ON = 2'h1;
    localparam logic [1:0] SW_SECOND_ON = 2'h2;
    localparam logic [1:0] SW_BOTH_ON  = 2'h3;

    // ****************************************
    // Fail-safe setting per output
    // ****************************************
    localparam logic [1:0] FS_KEEP_LAST_VALUE = 2'h0;
    localparam logic [1:0] FS_PREDEF_0        = 2'h1;
    localparam logic [1:0] FS_PREDEF_1        = 2'h2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_OUT     = 16'h0000;
    localparam logic [15:0] RST_FLAGS   = 16'h0000;
    localparam logic [2:0]  RST_SYNC    = 3'h0;

    // Startup latch-reset pulse length, cycles
    localparam int STARTUP_PULSE_CYC = 4;

    typedef enum logic [3:0] {
        ST_STARTUP = 4'h1,
        ST_RUN     = 4'h2,
        ST_FAILSAFE = 4'h4,
        ST_SLEEP   = 4'h8
    } ctrl_state_t;

endpackage

// ---- input_sync3.sv ----
// Three-stage synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to i_clk_sys.
`timescale 1ns/1ns
module input_sync3 (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_async,
    output logic      o_level
);
    logic [2:0] sync_r;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_r <= relay_output_pkg::RST_SYNC;
        end else begin
            sync_r <= {sync_r[1:0], i_async};
        end
    end

    // Change accepted once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_level <= 1'b0;
        end else if (sync_r[1] == sync_r[2]) begin
            o_level <= sync_r[2];
        end
    end
endmodule

// ---- relay_bank_model.sv ----
// Behavioural relay bank: back indication follows the drive after a delay.
// Assumes drive comes from the controller; i_stuck inverts chosen feedbacks.
`timescale 1ns/1ns
module relay_bank_model #(
    parameter int N   = 8,
    parameter int DLY = 2
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    input  wire logic [N-1:0] i_drive,
    input  wire logic [N-1:0] i_stuck,
    output logic [N-1:0]      o_back
);
    logic [N-1:0] pipe_r [DLY];

    // Contact travel time
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < DLY; i++) pipe_r[i] <= '0;
        end else begin
            pipe_r[0] <= i_drive;
            for (int i = 1; i < DLY; i++) pipe_r[i] <= pipe_r[i-1];
        end
    end

    // Stuck contact shows the opposite position
    assign o_back = pipe_r[DLY-1] ^ i_stuck;
endmodule

// ---- relay_output_controller_tb_top.sv ----
// Testbench for the eight-channel energized and sixteen-channel latching relay output controller.
// Assumes the relay bank model as far side; the bench plays the CPU.
`timescale 1ns/1ns
module relay_output_controller_tb_top;
    localparam int N = relay_output_pkg::N_CH_8;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [N-1:0] user_value = '0, mask = '0, predef = '0, stuck = '0, back, drive, latch_rst, form_c, mism;
    logic prog_run = 1'b1, link_ok = 1'b1, start_rst_en = 1'b1, sw_inh_en = 1'b1, inh_pin = 1'b1;
    logic sleep_req = 1'b0, freeze_req = 1'b0, fault = 1'b0, mism_read = 1'b0;
    logic [2*N-1:0] fs_cfg = '0;
    logic [1:0] mode_sw = relay_output_pkg::SW_BOTH_ON;
    logic inhibited, failure, err_led, sleeping;
    int n_errors = 0;
    int comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    relay_output_controller #(.N_CH(N), .LATCHING_TYPE(1'b0)) relay_output_controller_i (
        .i_clk_sys(clk_sys), .i_rstn(rstn), .i_user_value(user_value), .i_program_running(prog_run),
        .i_cpu_link_ok(link_ok), .i_failsafe_cfg(fs_cfg), .i_mask(mask), .i_predefined_value(predef),
        .i_startup_reset_en(start_rst_en), .i_sw_inhibit_en(sw_inh_en), .i_inhibit_mode_switch(mode_sw),
        .i_inhibit_control_input(inh_pin), .i_sleep_req(sleep_req), .i_freeze_req(freeze_req),
        .i_module_fault(fault), .i_back_indication(back), .i_mismatch_read(mism_read),
        .o_relay_drive(drive), .o_latch_reset(latch_rst), .o_form_c(form_c), .o_mismatch(mism),
        .o_inhibited(inhibited), .o_failure(failure), .o_err_led(err_led), .o_sleeping(sleeping));

    relay_bank_model #(.N(N), .DLY(2)) relay_bank_model_i (
        .i_clk_sys(clk_sys), .i_rstn(rstn), .i_drive(drive), .i_stuck(stuck), .o_back(back));

    // Sixteen-channel latching variant on the same controls, both byte halves alike
    logic [15:0] drive16, latch_rst16, form_c16, mism16, back16;
    logic        inhibited16, failure16, err_led16, sleeping16;

    if (1) begin : g_ml
        relay_output_controller #(.N_CH(16), .LATCHING_TYPE(1'b1)) relay_output_controller_i (
            .i_clk_sys(clk_sys), .i_rstn(rstn), .i_user_value({user_value, user_value}),
            .i_program_running(prog_run), .i_cpu_link_ok(link_ok), .i_failsafe_cfg({fs_cfg, fs_cfg}),
            .i_mask({mask, mask}), .i_predefined_value({predef, predef}), .i_startup_reset_en(start_rst_en),
            .i_sw_inhibit_en(sw_inh_en), .i_inhibit_mode_switch(mode_sw), .i_inhibit_control_input(inh_pin),
            .i_sleep_req(sleep_req), .i_freeze_req(freeze_req), .i_module_fault(fault),
            .i_back_indication(back16), .i_mismatch_read(mism_read), .o_relay_drive(drive16),
            .o_latch_reset(latch_rst16), .o_form_c(form_c16), .o_mismatch(mism16), .o_inhibited(inhibited16),
            .o_failure(failure16), .o_err_led(err_led16), .o_sleeping(sleeping16));

        relay_bank_model #(.N(16), .DLY(2)) relay_bank_model_i (
            .i_clk_sys(clk_sys), .i_rstn(rstn), .i_drive(drive16), .i_stuck({stuck, stuck}), .o_back(back16));
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic read_flags();
        @(posedge clk_sys);
        mism_read <= 1'b1;
        @(posedge clk_sys);
        mism_read <= 1'b0;
    endtask

    function automatic logic [7:0] fs_expect(input logic [7:0] prev, input logic [15:0] cfg);
        logic [7:0] r;
        r = prev;
        for (int i = 0; i < 8; i++) begin
            if (cfg[2*i+:2] === relay_output_pkg::FS_PREDEF_0) r[i] = 1'b0;
            else if (cfg[2*i+:2] === relay_output_pkg::FS_PREDEF_1) r[i] = 1'b1;
        end
        return r;
    endfunction

    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_startup();
        wt(2);
        chk("drive", 16'h0000, drive);
        chk("form_c", 16'h00E0, form_c);
        chk("form_c_ml", 16'hE0E0, form_c16);
        chk("latch_reset", 16'h0000, latch_rst);
        chk("latch_reset_ml", 16'hFFFF, latch_rst16);
        wt(6);
        chk("latch_reset_ml", 16'h0000, latch_rst16);
    endtask

    task automatic t_run_mask();
        @(posedge clk_sys);
        user_value <= 8'hA5;
        wt(3);
        chk("drive", 16'h00A5, drive);
        @(posedge clk_sys);
        mask <= 8'h0F;
        predef <= 8'h03;
        wt(3);
        chk("drive", 16'h00A3, drive);
        @(posedge clk_sys);
        mask <= 8'h00;
        wt(3);
    endtask

    task automatic t_failsafe();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            user_value <= 8'hA5;
            prog_run <= 1'b1;
            link_ok <= 1'b1;
            fs_cfg <= 16'h6186;
            wt(4);
            @(posedge clk_sys);
            if (k == 0) prog_run <= 1'b0;
            else link_ok <= 1'b0;
            @(posedge clk_sys);
            user_value <= 8'h5A;
            wt(4);
            chk("drive", {8'h00, fs_expect(8'hA5, 16'h6186)}, drive);
        end
        @(posedge clk_sys);
        prog_run <= 1'b1;
        link_ok <= 1'b1;
        user_value <= 8'hA5;
        wt(4);
    endtask

    task automatic t_freeze();
        @(posedge clk_sys);
        freeze_req <= 1'b1;
        @(posedge clk_sys);
        user_value <= 8'h3C;
        wt(4);
        chk("drive", 16'h00A5, drive);
        @(posedge clk_sys);
        freeze_req <= 1'b0;
        wt(3);
        chk("drive", 16'h003C, drive);
    endtask

    task automatic t_inhibit();
        logic [1:0] sw [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
        logic       en [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        @(posedge clk_sys);
        inh_pin <= 1'b0;
        stuck <= 8'h01;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_sys);
            mode_sw <= sw[k];
            sw_inh_en <= en[k];
            wt(12);
            read_flags();
            wt(4);
            chk("inhibited", {15'h0000, ex[k]}, {15'h0000, inhibited});
            chk("drive", ex[k] ? 16'h0000 : 16'h003C, drive);
            chk("drive_ml", 16'h3C3C, drive16);
            chk("mismatch", ex[k] ? 16'h0000 : 16'h0001, mism);
        end
        @(posedge clk_sys);
        inh_pin <= 1'b1;
        stuck <= 8'h00;
        mode_sw <= relay_output_pkg::SW_BOTH_ON;
        wt(12);
        read_flags();
        wt(2);
    endtask

    task automatic t_mismatch();
        @(posedge clk_sys);
        stuck <= 8'h10;
        wt(10);
        chk("mismatch", 16'h0010, mism);
        @(posedge clk_sys);
        stuck <= 8'h00;
        wt(10);
        chk("mismatch", 16'h0010, mism);
        read_flags();
        wt(2);
        chk("mismatch", 16'h0000, mism);
    endtask

    task automatic t_fault_sleep();
        @(posedge clk_sys);
        fault <= 1'b1;
        user_value <= 8'h81;
        wt(3);
        chk("drive", 16'h0000, drive);
        chk("drive_ml", 16'h3C3C, drive16);
        chk("failure", 16'h0001, {15'h0000, failure});
        chk("err_led", 16'h0001, {15'h0000, err_led});
        @(posedge clk_sys);
        fault <= 1'b0;
        wt(4);
        chk("drive", 16'h0081, drive);
        chk("drive_ml", 16'h8181, drive16);
        @(posedge clk_sys);
        sleep_req <= 1'b1;
        @(posedge clk_sys);
        user_value <= 8'hC3;
        wt(4);
        chk("sleeping", 16'h0001, {15'h0000, sleeping});
        chk("drive", 16'h0081, drive);
    endtask

    task automatic t_restart();
        @(posedge clk_sys);
        rstn <= 1'b0;
        sleep_req <= 1'b0;
        start_rst_en <= 1'b0;
        wt(3);
        @(posedge clk_sys);
        rstn <= 1'b1;
        wt(2);
        chk("latch_reset_ml", 16'h0000, latch_rst16);
        chk("drive", 16'h0000, drive);
        wt(6);
        chk("sleeping", 16'h0000, {15'h0000, sleeping});
        chk("drive", 16'h00C3, drive);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_startup();
        t_run_mask();
        t_failsafe();
        t_freeze();
        t_inhibit();
        t_mismatch();
        t_fault_sleep();
        t_restart();
        close_out();
    end

    initial begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule
